// *** hdl/ldsc_config_two.sv ***
/*
  Second configuration word of a 16-channel LED driver: serial shift, load,
  decoded controls, clock loss watch, standby, PWM start timing.
  Assumes serial pins and the grayscale clock arrive asynchronously; command
  pulses and PWM status come from logic on clk_sys.
*/
// Overview of operation
// - Word is shifted in MSB first, bit 15 first, bit 0 last.
// - Bit 15 one disables overtemperature shutdown; zero keeps it.
// - Bit 14 one disables grayscale clock loss detection.
// - Clock seen once then absent one second forces all outputs off.
// - Forced off ends on init command or renewed grayscale clock.
// - Bit 13 one enables open output detection.
// - Bit 12 one enables shorted output detection.
// - Bit 11 selects asynchronous PWM update; zero synchronous.
// - Bit 10 selects divided PWM output; zero single pulse.
// - Bit 9 enables standby two, only with 16-bit resolution.
// - Standby entered when PWM registers one and three are all zero.
// - Standby keeps all data and still accepts serial input.
// - Any nonzero data gives pre-standby, behaving as normal.
// - Leaving standby takes about 30 microseconds before normal.
// - Bit 8 selects second short detection threshold.
// - Bit 7 one disables staggered output delay.
// - Bit 6 selects falling serial clock edge for data out.
// - Bit 5 zero repeats PWM until reset command.
// - Bit 5 one gives one PWM cycle per output command.
// - Load happens only after 15 or 16 clocks while latch high.
// - Async restarts PWM at once; sync waits for cycle end only while PWM runs, else starts at once.
// - Divided output uses 128 equal segments per period.
// - With shutdown enabled, overtemperature turns all outputs off.
`timescale 1ns/1ps
`default_nettype none
module ldsc_config_two
  import ldsc_pkg::*;
#(
  parameter longint LOSS_CYC = LOSS_CYCLES,
  parameter int WAKE_CYC = int'(WAKE_CYCLES)
)
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic serial_clock,
  input wire logic serial_data_in,
  input wire logic latch_line,
  input wire logic grayscale_clock,
  input wire logic overtemp_flag,
  input wire logic init_command,
  input wire logic output_commit_command,
  input wire logic pwm_cycle_end,
  input wire logic pwm_res_16bit,
  input wire logic pwm_regs_all_zero,
  output logic serial_data_out,
  output ldsc_cfg_t config_fields,
  output logic [7:0] pwm_segments,
  output logic outputs_forced_off,
  output logic analog_power_on,
  output logic analog_ready,
  output logic pwm_start,
  output logic pwm_running
);

  logic [2:0] sck_sync_r;
  logic [1:0] sdi_sync_r;
  logic [2:0] lat_sync_r;
  logic [2:0] gck_sync_r;
  logic [1:0] ot_sync_r;
  logic sck_rise;
  logic sck_fall;
  logic lat_rise;
  logic lat_fall;
  logic gck_edge;
  logic [15:0] shift_r;
  logic [4:0] pulse_cnt_r;
  logic [15:0] cfg_r;
  logic serial_data_out_r;
  ldsc_loss_t loss_r;
  logic [31:0] loss_cnt_r;
  logic standby;
  logic standby_d_r;
  logic [15:0] wake_cnt_r;
  logic pending_r;
  logic start_r;
  logic run_r;

  // Two-stage synchronisers; third stage only for edge finding
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sck_sync_r <= 3'h0;
      sdi_sync_r <= 2'h0;
      lat_sync_r <= 3'h0;
      gck_sync_r <= 3'h0;
      ot_sync_r <= 2'h0;
    end
    else
    begin
      sck_sync_r <= {sck_sync_r[1:0], serial_clock};
      sdi_sync_r <= {sdi_sync_r[0], serial_data_in};
      lat_sync_r <= {lat_sync_r[1:0], latch_line};
      gck_sync_r <= {gck_sync_r[1:0], grayscale_clock};
      ot_sync_r <= {ot_sync_r[0], overtemp_flag};
    end
  end

  // Edges of synchronised levels
  assign sck_rise = sck_sync_r[1] & ~sck_sync_r[2];
  assign sck_fall = ~sck_sync_r[1] & sck_sync_r[2];
  assign lat_rise = lat_sync_r[1] & ~lat_sync_r[2];
  assign lat_fall = ~lat_sync_r[1] & lat_sync_r[2];
  assign gck_edge = gck_sync_r[1] ^ gck_sync_r[2];

  // Serial shift, MSB enters first and ends at bit 15
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      shift_r <= 16'h0000;
    else if (sck_rise)
      shift_r <= {shift_r[14:0], sdi_sync_r[1]};
  end

  // Clock pulses counted while latch is high, saturating
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      pulse_cnt_r <= 5'h00;
    else if (lat_rise)
      pulse_cnt_r <= 5'h00;
    else if (lat_sync_r[1] && sck_rise && pulse_cnt_r != 5'h1f)
      pulse_cnt_r <= pulse_cnt_r + 5'h01;
  end

  // Configuration word: load at latch fall, clear on init
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      cfg_r <= CFG_RESET;
    else if (init_command)
      cfg_r <= CFG_RESET;
    else if (lat_fall && (pulse_cnt_r == LOAD_PULSES_A || pulse_cnt_r == LOAD_PULSES_B))
      cfg_r <= {shift_r[15:5], 5'h00};
  end

  // Field decode, one process drives the whole struct
  always_comb
  begin
    config_fields.tsd_off = cfg_r[BIT_TSD_OFF];
    config_fields.loss_detect_off = cfg_r[BIT_LOSS_OFF];
    config_fields.open_detect_en = cfg_r[BIT_OPEN_EN];
    config_fields.short_detect_en = cfg_r[BIT_SHORT_EN];
    config_fields.async_update = cfg_r[BIT_ASYNC];
    config_fields.divided_output = cfg_r[BIT_DIVIDED];
    config_fields.standby2_en = cfg_r[BIT_STBY2_EN];
    config_fields.short_threshold_two = cfg_r[BIT_SHORT_THR2];
    config_fields.delay_off = cfg_r[BIT_DELAY_OFF];
    config_fields.serial_data_out_falling = cfg_r[BIT_SERIAL_DATA_OUT_FALL];
    config_fields.one_shot = cfg_r[BIT_ONE_SHOT];
  end

  // Segment count for the PWM engine, one when not divided
  assign pwm_segments = cfg_r[BIT_DIVIDED] ? DIV_SEGMENTS : 8'h01;

  // Serial data out changes on the selected clock edge
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      serial_data_out_r <= 1'b0;
    else if (cfg_r[BIT_SERIAL_DATA_OUT_FALL] ? sck_fall : sck_rise)
      serial_data_out_r <= shift_r[15];
  end

  assign serial_data_out = serial_data_out_r;

  // Grayscale clock loss monitor
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      loss_r <= LDSC_LS_IDLE;
      loss_cnt_r <= 32'h0;
    end
    else if (init_command || cfg_r[BIT_LOSS_OFF])
    begin
      loss_r <= LDSC_LS_IDLE;
      loss_cnt_r <= 32'h0;
    end
    else
    begin
      case (loss_r)
        LDSC_LS_IDLE:
        begin
          loss_cnt_r <= 32'h0;
          if (gck_edge)
            loss_r <= LDSC_LS_WATCH;
        end
        LDSC_LS_WATCH:
        begin
          if (gck_edge)
            loss_cnt_r <= 32'h0;
          else if (loss_cnt_r >= 32'(LOSS_CYC - 1))
            loss_r <= LDSC_LS_OFF;
          else
            loss_cnt_r <= loss_cnt_r + 32'h1;
        end
        LDSC_LS_OFF:
        begin
          loss_cnt_r <= 32'h0;
          if (gck_edge)
            loss_r <= LDSC_LS_WATCH;
        end
        default:
        begin
          loss_r <= LDSC_LS_IDLE;
          loss_cnt_r <= 32'h0;
        end
      endcase
    end
  end

  // All outputs off on clock loss or overtemperature
  assign outputs_forced_off = (loss_r == LDSC_LS_OFF) |
                              (ot_sync_r[1] & ~cfg_r[BIT_TSD_OFF]);

  // Standby two: data-dependent, only at 16-bit resolution
  assign standby = cfg_r[BIT_STBY2_EN] & pwm_res_16bit & pwm_regs_all_zero;
  assign analog_power_on = ~standby;

  // Wake delay after leaving standby
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      standby_d_r <= 1'b0;
      wake_cnt_r <= 16'h0;
    end
    else
    begin
      standby_d_r <= standby;
      if (standby)
        wake_cnt_r <= 16'h0;
      else if (standby_d_r)
        wake_cnt_r <= 16'(WAKE_CYC);
      else if (wake_cnt_r != 16'h0)
        wake_cnt_r <= wake_cnt_r - 16'h1;
    end
  end

  assign analog_ready = ~standby & ~standby_d_r & (wake_cnt_r == 16'h0);

  // PWM start timing: async or idle now, sync while running at cycle end with latest data
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pending_r <= 1'b0;
      start_r <= 1'b0;
    end
    else if (init_command)
    begin
      pending_r <= 1'b0;
      start_r <= 1'b0;
    end
    else if (output_commit_command && (cfg_r[BIT_ASYNC] || !run_r))
    begin
      pending_r <= 1'b0;
      start_r <= 1'b1;
    end
    else if (output_commit_command)
    begin
      pending_r <= 1'b1;
      start_r <= 1'b0;
    end
    else if (pending_r && pwm_cycle_end)
    begin
      pending_r <= 1'b0;
      start_r <= 1'b1;
    end
    else
      start_r <= 1'b0;
  end

  assign pwm_start = start_r;

  // Run flag: repeat until init, one-shot stops at cycle end
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      run_r <= 1'b0;
    else if (init_command)
      run_r <= 1'b0;
    else if (start_r)
      run_r <= 1'b1;
    else if (pwm_cycle_end && cfg_r[BIT_ONE_SHOT] && !pending_r)
      run_r <= 1'b0;
  end

  assign pwm_running = run_r;

endmodule // ldsc_config_two
`default_nettype wire

// *** common/ldsc_pkg.sv ***
/*
  Shared constants and types for the second configuration word of the LED driver.
  Assumes a 25 MHz system clock and a serial host that shifts MSB first.
*/
`default_nettype none
package ldsc_pkg;
  // Word geometry
  localparam int WORD_W = 16;
  localparam logic [4:0] LOAD_PULSES_A = 5'h0f;
  localparam logic [4:0] LOAD_PULSES_B = 5'h10;
  // Field positions inside the word
  localparam int BIT_TSD_OFF = 15;
  localparam int BIT_LOSS_OFF = 14;
  localparam int BIT_OPEN_EN = 13;
  localparam int BIT_SHORT_EN = 12;
  localparam int BIT_ASYNC = 11;
  localparam int BIT_DIVIDED = 10;
  localparam int BIT_STBY2_EN = 9;
  localparam int BIT_SHORT_THR2 = 8;
  localparam int BIT_DELAY_OFF = 7;
  localparam int BIT_SERIAL_DATA_OUT_FALL = 6;
  localparam int BIT_ONE_SHOT = 5;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  // Divided output splits a period into this many segments
  localparam logic [7:0] DIV_SEGMENTS = 8'h80;
  // Timing
  localparam longint CLK_HZ = 25000000;
  localparam longint CLK_PERIOD_NS = 40;
  localparam longint LOSS_TIME_MS = 1000;
  localparam longint LOSS_CYCLES = CLK_HZ / 1000 * LOSS_TIME_MS;
  localparam longint WAKE_TIME_NS = 30000;
  localparam longint WAKE_CYCLES = (WAKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Decoded configuration fields
  typedef struct packed {
    logic tsd_off;
    logic loss_detect_off;
    logic open_detect_en;
    logic short_detect_en;
    logic async_update;
    logic divided_output;
    logic standby2_en;
    logic short_threshold_two;
    logic delay_off;
    logic serial_data_out_falling;
    logic one_shot;
  } ldsc_cfg_t;

  // Clock loss monitor states, Gray along the path
  typedef enum logic [1:0] {
    LDSC_LS_IDLE = 2'b00,
    LDSC_LS_WATCH = 2'b01,
    LDSC_LS_OFF = 2'b11
  } ldsc_loss_t;
endpackage
`default_nettype wire

// *** sim/ldsc_monitor.sv ***
/*
  Checker for the second configuration word block.
  Assumes a bind onto ldsc_config_two; sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module ldsc_monitor
  import ldsc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic overtemp_flag,
  input wire logic init_command,
  input wire logic output_commit_command,
  input wire logic pwm_cycle_end,
  input wire logic pwm_res_16bit,
  input wire logic pwm_regs_all_zero,
  input wire ldsc_cfg_t config_fields,
  input wire logic [7:0] pwm_segments,
  input wire logic outputs_forced_off,
  input wire logic analog_power_on,
  input wire logic analog_ready,
  input wire logic pwm_start,
  input wire logic pwm_running
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // Output scheme and power state
  a_seg_select:
    assert property (pwm_segments == (config_fields.divided_output ? DIV_SEGMENTS : 8'h01))
      else $error("segment count wrong");
  a_standby_off:
    assert property (config_fields.standby2_en && pwm_res_16bit && pwm_regs_all_zero
      |-> !analog_power_on) else $error("standby not entered");
  a_prestandby_on:
    assert property (!config_fields.standby2_en || !pwm_res_16bit || !pwm_regs_all_zero
      |-> analog_power_on) else $error("power off outside standby");
  a_wake_delay:
    assert property ($rose(analog_power_on) |-> !analog_ready [*8])
      else $error("ready too early after standby");
  // Commands and protection
  a_init_clear:
    assert property (init_command |=> config_fields == 11'h000 && !pwm_running)
      else $error("init did not clear");
  a_async_start:
    assert property (output_commit_command && !init_command && config_fields.async_update
      |=> pwm_start) else $error("async start missing");
  a_sync_wait:
    assert property (output_commit_command && !config_fields.async_update && pwm_running
      && !pwm_cycle_end |=> !pwm_start) else $error("sync start too early");
  a_overtemp_off:
    assert property ((overtemp_flag && !config_fields.tsd_off) [*4] |-> outputs_forced_off)
      else $error("overtemp did not cut outputs");
endmodule // ldsc_monitor
`default_nettype wire

// *** sim/ldsc_host.sv ***
/*
  Host model driving the serial word link of the configuration block.
  Assumes a 25 MHz clk_sys; link clock period 320 ns, still between frames.
*/
`timescale 1ns/1ps
`default_nettype none
module ldsc_host (
  input wire logic clk_sys,
  output logic serial_clock,
  output logic serial_data_in,
  output logic latch_line
);
  // Idle link
  initial
  begin
    serial_clock = 1'b0;
    serial_data_in = 1'b0;
    latch_line = 1'b0;
  end
  // Send low n bits of w, MSB first, under latch
  task automatic send(input logic [15:0] w, input int n);
    @(posedge clk_sys);
    #1 latch_line = 1'b1;
    // Link clock period 320 ns; data changes with the falling edge
    for (int i = n - 1; i >= 0; i--)
    begin
      #160 serial_clock = 1'b0;
      serial_data_in = w[i];
      #160 serial_clock = 1'b1;
    end
    #160 serial_clock = 1'b0;
    #160 latch_line = 1'b0;
    serial_data_in = ~serial_data_in;
    #160;
  endtask
endmodule // ldsc_host
`default_nettype wire

// *** sim/tb_top.sv ***
/*
  Self-checking bench for the second configuration word block.
  Assumes ldsc_host as link partner and ldsc_monitor bound below.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin failures++; \
  $display("CHECK FAILED %0t value mismatch", $time); end end
module tb_top
  import ldsc_pkg::*;
;
  logic clk_sys, reset_n, serial_clock, serial_data_in, latch_line, grayscale_clock;
  logic overtemp_flag, init_command, output_commit_command, pwm_cycle_end;
  logic pwm_res_16bit, pwm_regs_all_zero, serial_data_out, outputs_forced_off;
  logic analog_power_on, analog_ready, pwm_start, pwm_running;
  logic [7:0] pwm_segments;
  ldsc_cfg_t config_fields;
  int failures, check_count, cycles;
  // Block with short loss limit, and its host
  ldsc_config_two #(.LOSS_CYC(200)) i_dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .serial_clock(serial_clock),
    .serial_data_in(serial_data_in), .latch_line(latch_line),
    .grayscale_clock(grayscale_clock), .overtemp_flag(overtemp_flag),
    .init_command(init_command), .output_commit_command(output_commit_command),
    .pwm_cycle_end(pwm_cycle_end), .pwm_res_16bit(pwm_res_16bit),
    .pwm_regs_all_zero(pwm_regs_all_zero), .serial_data_out(serial_data_out),
    .config_fields(config_fields), .pwm_segments(pwm_segments),
    .outputs_forced_off(outputs_forced_off), .analog_power_on(analog_power_on),
    .analog_ready(analog_ready), .pwm_start(pwm_start), .pwm_running(pwm_running)
  );
  ldsc_host i_host (
    .clk_sys(clk_sys), .serial_clock(serial_clock),
    .serial_data_in(serial_data_in), .latch_line(latch_line)
  );
  // System clock
  initial
  begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // Hang guard
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    step(1);
    s = 1'b0;
  endtask
  task automatic load(input logic [15:0] w);
    i_host.send(w, 16);
    step(1);
  endtask
  task automatic t_load();
    `CHK(config_fields, 11'h000)
    load(16'hffe0);
    `CHK(config_fields, 11'h7ff)
    `CHK(pwm_segments, DIV_SEGMENTS)
    load(16'hffe0);
    `CHK(serial_data_out, 1'b1)
    i_host.send(16'h0000, 14);
    `CHK(config_fields, 11'h7ff)
    load(16'h2aa0);
    `CHK(config_fields, 11'h155)
    pulse(init_command);
    step(1);
    `CHK(config_fields, 11'h000)
    `CHK(pwm_segments, 8'h01)
    $display("test load done");
  endtask
  task automatic t_cmd();
    load(16'h0800);
    pulse(output_commit_command);
    `CHK(pwm_start, 1'b1)
    step(1);
    load(16'h0000);
    pulse(output_commit_command);
    `CHK(pwm_start, 1'b0)
    step(2);
    pulse(pwm_cycle_end);
    `CHK(pwm_start, 1'b1)
    step(1);
    pulse(pwm_cycle_end);
    step(2);
    `CHK(pwm_running, 1'b1)
    load(16'h0020);
    pulse(pwm_cycle_end);
    step(2);
    `CHK(pwm_running, 1'b0)
    pulse(output_commit_command);
    `CHK(pwm_start, 1'b1)
    step(1);
    `CHK(pwm_running, 1'b1)
    $display("test commands done");
  endtask
  task automatic t_prot();
    pulse(init_command);
    overtemp_flag = 1'b1;
    step(5);
    `CHK(outputs_forced_off, 1'b1)
    load(16'h8000);
    `CHK(outputs_forced_off, 1'b0)
    overtemp_flag = 1'b0;
    load(16'h0000);
    grayscale_clock = 1'b1;
    step(5);
    `CHK(outputs_forced_off, 1'b0)
    step(210);
    `CHK(outputs_forced_off, 1'b1)
    grayscale_clock = 1'b0;
    step(5);
    `CHK(outputs_forced_off, 1'b0)
    step(210);
    `CHK(outputs_forced_off, 1'b1)
    pulse(init_command);
    step(1);
    `CHK(outputs_forced_off, 1'b0)
    load(16'h4000);
    grayscale_clock = 1'b1;
    step(220);
    `CHK(outputs_forced_off, 1'b0)
    $display("test protection done");
  endtask
  task automatic t_standby();
    pwm_res_16bit = 1'b1;
    pwm_regs_all_zero = 1'b1;
    step(1);
    `CHK(analog_power_on, 1'b1)
    load(16'h0200);
    `CHK(analog_power_on, 1'b0)
    load(16'h0a00);
    `CHK(config_fields, 11'h050)
    pwm_regs_all_zero = 1'b0;
    step(1);
    `CHK(analog_power_on, 1'b1)
    step(745);
    `CHK(analog_ready, 1'b0)
    step(10);
    `CHK(analog_ready, 1'b1)
    $display("test standby done");
  endtask
  // Main sequence
  initial
  begin
    {reset_n, grayscale_clock, overtemp_flag, init_command} = 4'h0;
    {output_commit_command, pwm_cycle_end, pwm_res_16bit, pwm_regs_all_zero} = 4'h0;
    repeat (16) @(posedge clk_sys);
    #1 reset_n = 1'b1;
    step(1);
    t_load();
    t_cmd();
    t_prot();
    t_standby();
    results();
  end
endmodule // tb_top
bind ldsc_config_two ldsc_monitor i_mon (
  .clk_sys(clk_sys), .reset_n(reset_n), .overtemp_flag(overtemp_flag),
  .init_command(init_command), .output_commit_command(output_commit_command),
  .pwm_cycle_end(pwm_cycle_end), .pwm_res_16bit(pwm_res_16bit),
  .pwm_regs_all_zero(pwm_regs_all_zero), .config_fields(config_fields),
  .pwm_segments(pwm_segments), .outputs_forced_off(outputs_forced_off),
  .analog_power_on(analog_power_on), .analog_ready(analog_ready),
  .pwm_start(pwm_start), .pwm_running(pwm_running)
);
`default_nettype wire
